// ---- inc/scb_regs.svh ----
`ifndef SCB_REGS_SVH
`define SCB_REGS_SVH

// Register byte addresses on the AXI4-Lite slave
`define SCB_ADDR_CTRL      6'h00
`define SCB_ADDR_INSN      6'h04
`define SCB_ADDR_FLAGS     6'h08
`define SCB_ADDR_IP        6'h0c
`define SCB_ADDR_STATUS    6'h10
`define SCB_ADDR_NEXT_IP   6'h14
`define SCB_ADDR_CYCLES    6'h18

// Field positions
`define SCB_CTRL_START     0
`define SCB_INSN_OPC_LSB   0
`define SCB_INSN_DISP_LSB  8
`define SCB_FLAG_ZERO      0
`define SCB_FLAG_SIGN      1
`define SCB_FLAG_OVERFLOW  2
`define SCB_FLAG_PARITY    3
`define SCB_STAT_BUSY      0
`define SCB_STAT_DONE      1
`define SCB_STAT_TAKEN     2
`define SCB_STAT_UNSUP     3

// Reset values
`define SCB_RST_INSN       16'h0000
`define SCB_RST_FLAGS      4'h0
`define SCB_RST_IP         16'h0000

// Opcodes handled here
`define SCB_OPC_GREATER    8'h7f
`define SCB_OPC_NO_OVF     8'h71
`define SCB_OPC_PAR_CLEAR  8'h7b
`define SCB_OPC_POSITIVE   8'h79
`define SCB_OPC_NONZERO    8'h75
`define SCB_OPC_OVERFLOW   8'h70
`define SCB_OPC_PAR_SET    8'h7a

// Sign extension masks and instruction length
`define SCB_EXT_NEG        16'hff00
`define SCB_EXT_POS        16'h00ff
`define SCB_INSN_LEN       16'h0002

// Cycle counts
`define SCB_CLK_TAKEN      4'hd
`define SCB_CLK_NOT_TAKEN  4'h4

// AXI responses
`define SCB_RESP_OKAY      2'h0
`define SCB_RESP_SLVERR    2'h2

`endif

// ---- inc/scb_pkg.sv ----
package scb_pkg;

	typedef enum logic {
		SCB_IDLE,
		SCB_RUN
	} scb_state_t;

	typedef struct packed {
		logic parity_flag;
		logic overflow_flag;
		logic sign_flag;
		logic zero_flag;
	} scb_flags_t;

endpackage

// ---- inc/scb_if.sv ----
`timescale 1ns/1ps

interface scb_if;
	logic [7:0]         opcode;
	logic [7:0]         short_displacement;
	scb_pkg::scb_flags_t flags;
	logic [15:0]        instruction_pointer;
	logic               supported;
	logic               taken;
	logic [15:0]        target_ip;
	logic [3:0]         cycles;

	modport core (
		output opcode,
		output short_displacement,
		output flags,
		output instruction_pointer,
		input  supported,
		input  taken,
		input  target_ip,
		input  cycles
	);

	modport eval (
		input  opcode,
		input  short_displacement,
		input  flags,
		input  instruction_pointer,
		output supported,
		output taken,
		output target_ip,
		output cycles
	);
endinterface

// ---- rtl/scb_eval.sv ----
`timescale 1ns/1ps
`include "scb_regs.svh"

module scb_eval (
	scb_if.eval e      // Decoded branch in, verdict out
);

	logic [15:0] ext;
	logic [15:0] fall_ip;
	logic        cond;
	logic        known;

	// Widen displacement exactly as the two-mask form does
	always_comb
	begin
		if (e.short_displacement[7])
			ext = `SCB_EXT_NEG | {8'h00, e.short_displacement}; // [RULE8]
		else
			ext = `SCB_EXT_POS & {8'h00, e.short_displacement}; // [RULE8]
	end

	// Base is the byte after the two-byte branch
	assign fall_ip = e.instruction_pointer + `SCB_INSN_LEN; // [RULE12]

	// Condition decode per opcode
	always_comb
	begin
		cond  = 1'b0;
		known = 1'b1;
		case (e.opcode)
			`SCB_OPC_GREATER:
				cond = !e.flags.zero_flag &&
					(e.flags.sign_flag == e.flags.overflow_flag); // [RULE1]
			`SCB_OPC_NO_OVF:    cond = !e.flags.overflow_flag; // [RULE2]
			`SCB_OPC_PAR_CLEAR: cond = !e.flags.parity_flag;   // [RULE3]
			`SCB_OPC_POSITIVE:  cond = !e.flags.sign_flag;     // [RULE4]
			`SCB_OPC_NONZERO:   cond = !e.flags.zero_flag;     // [RULE5]
			`SCB_OPC_OVERFLOW:  cond = e.flags.overflow_flag;  // [RULE6]
			`SCB_OPC_PAR_SET:   cond = e.flags.parity_flag;    // [RULE7]
			default:            known = 1'b0;
		endcase
	end

	// Wraps modulo 64 KiB, as the pointer does
	assign e.supported = known;
	assign e.taken     = known && cond;
	assign e.target_ip = e.taken ? fall_ip + ext : fall_ip; // [RULE9] [RULE10]
	assign e.cycles    = e.taken ? `SCB_CLK_TAKEN : `SCB_CLK_NOT_TAKEN; // [RULE11]

endmodule // scb_eval

// ---- rtl/scb_top.sv ----
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "scb_regs.svh"

// How it works
// [RULE1] Opcode 7F branches when zero clear and sign equals overflow.
// [RULE2] Opcode 71 branches when overflow is clear.
// [RULE3] Opcode 7B branches when parity is clear; both synonyms share it.
// [RULE4] Opcode 79 branches when sign is clear.
// [RULE5] Opcode 75 branches when zero is clear; nonzero and unequal share it.
// [RULE6] Opcode 70 branches when overflow is set.
// [RULE7] Opcode 7A branches when parity is set; both synonyms share it.
// [RULE8] Displacement widens: negative ORed with FF00, otherwise masked with 00FF.
// [RULE9] Taken branch loads pointer plus widened displacement, 16-bit wrap.
// [RULE10] Untaken branch simply continues with the following instruction.
// [RULE11] Taken costs 13 clocks, untaken 4, on either bus width.
// [RULE12] Displacement adds to the address just after the two-byte branch.
module scb_top (
	input  wire logic        aclk,     // Core clock, 100 MHz
	input  wire logic        aresetn,  // Synchronous reset, active low
	input  wire logic [5:0]  awaddr,   // Write address
	input  wire logic [2:0]  awprot,   // Unused protection
	input  wire logic        awvalid,  // Write address valid
	output logic             awready,  // Write address ready
	input  wire logic [31:0] wdata,    // Write data
	input  wire logic [3:0]  wstrb,    // Byte enables
	input  wire logic        wvalid,   // Write data valid
	output logic             wready,   // Write data ready
	output logic [1:0]       bresp,    // Write response
	output logic             bvalid,   // Write response valid
	input  wire logic        bready,   // Write response ready
	input  wire logic [5:0]  araddr,   // Read address
	input  wire logic [2:0]  arprot,   // Unused protection
	input  wire logic        arvalid,  // Read address valid
	output logic             arready,  // Read address ready
	output logic [31:0]      rdata,    // Read data
	output logic [1:0]       rresp,    // Read response
	output logic             rvalid,   // Read data valid
	input  wire logic        rready    // Read data ready
);

	scb_if bi ();

	// Write channel state
	logic        aw_have;
	logic        next_aw_have;
	logic [5:0]  aw_addr;
	logic [5:0]  next_aw_addr;
	logic        w_have;
	logic        next_w_have;
	logic [31:0] w_data;
	logic [31:0] next_w_data;
	logic [3:0]  w_strb;
	logic [3:0]  next_w_strb;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        wr_fire;
	logic [31:0] wmask;

	// Read channel state
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;

	// Configuration written by software
	logic [15:0]         insn;
	logic [15:0]         next_insn;
	scb_pkg::scb_flags_t flags;
	scb_pkg::scb_flags_t next_flags;
	logic [15:0]         ip;
	logic [15:0]         next_ip;

	// Execution state and results
	scb_pkg::scb_state_t state;
	scb_pkg::scb_state_t next_state;
	logic [3:0]          cnt;
	logic [3:0]          next_cnt;
	logic                done;
	logic                next_done;
	logic                taken;
	logic                next_taken;
	logic                unsup;
	logic                next_unsup;
	logic [15:0]         result_ip;
	logic [15:0]         next_result_ip;
	logic [3:0]          cycles;
	logic [3:0]          next_cycles;
	logic                start;
	logic                busy;

	// Feed the evaluator from the held configuration
	assign bi.opcode              = insn[`SCB_INSN_OPC_LSB +: 8];
	assign bi.short_displacement  = insn[`SCB_INSN_DISP_LSB +: 8];
	assign bi.flags               = flags;
	assign bi.instruction_pointer = ip;

	scb_eval u_eval (
		.e (bi.eval)
	);

	// Byte enables widened to a bit mask
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_mask
			assign wmask[gi*8 +: 8] = {8{w_strb[gi]}};
		end
	endgenerate

	assign busy    = (state == scb_pkg::SCB_RUN);
	assign awready = !aw_have && !bvalid;
	assign wready  = !w_have && !bvalid;
	assign arready = !rvalid;
	assign wr_fire = aw_have && w_have && !bvalid;
	assign start   = wr_fire && (aw_addr == `SCB_ADDR_CTRL) &&
		w_strb[0] && w_data[`SCB_CTRL_START] && !busy;

	// Write address and data captured in either order, answered together
	always_comb
	begin
		next_aw_have = aw_have;
		next_aw_addr = aw_addr;
		next_w_have  = w_have;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		if (awvalid && awready)
		begin
			next_aw_have = 1'b1;
			next_aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			next_w_have = 1'b1;
			next_w_data = wdata;
			next_w_strb = wstrb;
		end
		if (wr_fire)
		begin
			next_aw_have = 1'b0;
			next_w_have  = 1'b0;
			next_bvalid  = 1'b1;
			case (aw_addr)
				`SCB_ADDR_CTRL,
				`SCB_ADDR_INSN,
				`SCB_ADDR_FLAGS,
				`SCB_ADDR_IP,
				`SCB_ADDR_STATUS,
				`SCB_ADDR_NEXT_IP,
				`SCB_ADDR_CYCLES: next_bresp = `SCB_RESP_OKAY;
				default:          next_bresp = `SCB_RESP_SLVERR;
			endcase
		end
		else if (bvalid && bready)
			next_bvalid = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have <= 1'b0;
			aw_addr <= 6'h00;
			w_have  <= 1'b0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= `SCB_RESP_OKAY;
		end
		else
		begin
			aw_have <= next_aw_have;
			aw_addr <= next_aw_addr;
			w_have  <= next_w_have;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
		end
	end

	// Configuration is frozen while a branch runs so the verdict stays stable
	always_comb
	begin
		next_insn  = insn;
		next_flags = flags;
		next_ip    = ip;
		if (wr_fire && !busy)
		begin
			case (aw_addr)
				`SCB_ADDR_INSN:
					next_insn = (insn & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
				`SCB_ADDR_FLAGS:
					if (w_strb[0])
						next_flags = w_data[3:0];
				`SCB_ADDR_IP:
					next_ip = (ip & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
				default:
					next_insn = insn;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			insn  <= `SCB_RST_INSN;
			flags <= `SCB_RST_FLAGS;
			ip    <= `SCB_RST_IP;
		end
		else
		begin
			insn  <= next_insn;
			flags <= next_flags;
			ip    <= next_ip;
		end
	end

	// Branch timing: busy for exactly the reported clock count, then commit
	always_comb
	begin
		next_state     = state;
		next_cnt       = cnt;
		next_done      = done;
		next_taken     = taken;
		next_unsup     = unsup;
		next_result_ip = result_ip;
		next_cycles    = cycles;
		case (state)
			scb_pkg::SCB_IDLE:
				if (start)
				begin
					next_state  = scb_pkg::SCB_RUN;
					next_cnt    = bi.cycles - 4'h1;              // [RULE11]
					next_done   = 1'b0;
					next_unsup  = !bi.supported;
					next_cycles = bi.cycles;                     // [RULE11]
				end
			scb_pkg::SCB_RUN:
				if (cnt == 4'h0)
				begin
					next_state     = scb_pkg::SCB_IDLE;
					next_done      = 1'b1;
					next_taken     = bi.taken;
					next_result_ip = bi.target_ip;               // [RULE9] [RULE10]
				end
				else
					next_cnt = cnt - 4'h1;
			default:
				next_state = scb_pkg::SCB_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state     <= scb_pkg::SCB_IDLE;
			cnt       <= 4'h0;
			done      <= 1'b0;
			taken     <= 1'b0;
			unsup     <= 1'b0;
			result_ip <= 16'h0000;
			cycles    <= 4'h0;
		end
		else
		begin
			state     <= next_state;
			cnt       <= next_cnt;
			done      <= next_done;
			taken     <= next_taken;
			unsup     <= next_unsup;
			result_ip <= next_result_ip;
			cycles    <= next_cycles;
		end
	end

	// Read channel: one-cycle registered answer
	always_comb
	begin
		next_rvalid = rvalid;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (arvalid && arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = `SCB_RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			case (araddr)
				`SCB_ADDR_CTRL:    next_rdata = 32'h0000_0000;
				`SCB_ADDR_INSN:    next_rdata = {16'h0000, insn};
				`SCB_ADDR_FLAGS:   next_rdata = {28'h0000000, flags};
				`SCB_ADDR_IP:      next_rdata = {16'h0000, ip};
				`SCB_ADDR_STATUS:  next_rdata = {28'h0000000, unsup, taken, done, busy};
				`SCB_ADDR_NEXT_IP: next_rdata = {16'h0000, result_ip};
				`SCB_ADDR_CYCLES:  next_rdata = {28'h0000000, cycles};
				default:           next_rresp = `SCB_RESP_SLVERR;
			endcase
		end
		else if (rvalid && rready)
			next_rvalid = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `SCB_RESP_OKAY;
		end
		else
		begin
			rvalid <= next_rvalid;
			rdata  <= next_rdata;
			rresp  <= next_rresp;
		end
	end

endmodule // scb_top

// ---- dv/scb_top_checker.sv ----
`timescale 1ns/1ps
`include "scb_regs.svh"
module scb_top_checker (
	input logic        aclk,    // Clock
	input logic        aresetn, // Reset, low
	input logic [5:0]  awaddr,  // Write addr
	input logic        awvalid, // Aw valid
	input logic        awready, // Aw ready
	input logic        wvalid,  // W valid
	input logic        wready,  // W ready
	input logic [1:0]  bresp,   // B resp
	input logic        bvalid,  // B valid
	input logic        bready,  // B ready
	input logic [5:0]  araddr,  // Read addr
	input logic        arvalid, // Ar valid
	input logic        arready, // Ar ready
	input logic [31:0] rdata,   // R data
	input logic [1:0]  rresp,   // R resp
	input logic        rvalid,  // R valid
	input logic        rready   // R ready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Handshakes that open each answer
	sequence wr_take; awvalid && awready && wvalid && wready; endsequence
	sequence rd_take; arvalid && arready; endsequence
	sequence cyc_read; rd_take ##0 araddr == `SCB_ADDR_CYCLES; endsequence
	sequence bad_write; wr_take ##0 awaddr >= 6'h1c; endsequence
	// Both halves land in holding registers first, so the answer comes two edges later
	AST_B_ANSWER: assert property (wr_take |-> ##2 bvalid) else $error("write unanswered");
	AST_R_ANSWER: assert property (rd_take |=> rvalid) else $error("read unanswered");
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer dropped");
	AST_B_BLOCK: assert property (bvalid |-> !awready && !wready) else $error("write overlap");
	AST_R_BLOCK: assert property (rvalid |-> !arready) else $error("read overlap");
	AST_CYCLES: assert property (cyc_read |=> rdata inside {32'hd, 32'h4, 32'h0})
		else $error("bad clock count");
	AST_UNMAPPED: assert property (bad_write |-> ##2 bresp == `SCB_RESP_SLVERR)
		else $error("unmapped write accepted");
endmodule // scb_top_checker

// ---- dv/scb_exec_model.sv ----
`timescale 1ns/1ps
module scb_exec_model (
	input  logic        aclk,    // Clock
	output logic [5:0]  awaddr,  // Write addr
	output logic [2:0]  awprot,  // Zero
	output logic        awvalid, // Aw valid
	input  logic        awready, // Aw ready
	output logic [31:0] wdata,   // W data
	output logic [3:0]  wstrb,   // All bytes
	output logic        wvalid,  // W valid
	input  logic        wready,  // W ready
	input  logic [1:0]  bresp,   // B resp
	input  logic        bvalid,  // B valid
	output logic        bready,  // B ready
	output logic [5:0]  araddr,  // Read addr
	output logic [2:0]  arprot,  // Zero
	output logic        arvalid, // Ar valid
	input  logic        arready, // Ar ready
	input  logic [31:0] rdata,   // R data
	input  logic [1:0]  rresp,   // R resp
	input  logic        rvalid,  // R valid
	output logic        rready   // R ready
);
	bit slow = 0; // Ready waits a cycle after valid, to exercise held answers
	// Quiet bus from time zero
	initial
	begin
		{awaddr, awprot, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arprot, arvalid, rready} = '0;
		wstrb = 4'hf;
	end
	// Handshakes are judged at the rising edge, from the values that stood before it
	task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r,
		output bit ok);
		bit aw, w, b;
		ok = 0;
		r = 2'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !slow;
		for (int n = 0; n < 64 && !ok; n++)
		begin
			@(posedge aclk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid && bready;
			r = bresp;
			awvalid <= awvalid && !aw;
			wvalid <= wvalid && !w;
			bready <= !b && (bready || bvalid);
			ok = b;
		end
	endtask
	// One read, answer kept at the edge where rready meets rvalid
	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r,
		output bit ok);
		bit ar, hs;
		ok = 0;
		d = 32'h0000_0000;
		r = 2'h0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= !slow;
		for (int n = 0; n < 64 && !ok; n++)
		begin
			@(posedge aclk);
			ar = arvalid && arready;
			hs = rvalid && rready;
			d = rdata;
			r = rresp;
			arvalid <= arvalid && !ar;
			rready <= !hs && (rready || rvalid);
			ok = hs;
		end
	endtask
endmodule // scb_exec_model

// ---- dv/short_conditional_branch_unit_tb.sv ----
`timescale 1ns/1ps
`include "scb_regs.svh"
module short_conditional_branch_unit_tb;
	logic        aclk, aresetn;                                // Clock, reset
	logic [5:0]  awaddr, araddr;                               // Addresses
	logic [2:0]  awprot, arprot;                               // Protection
	logic [31:0] wdata, rdata;                                 // Data
	logic [3:0]  wstrb;                                        // Byte enables
	logic [1:0]  bresp, rresp;                                 // Responses
	logic        awvalid, awready, wvalid, wready, bvalid, bready; // Write side
	logic        arvalid, arready, rvalid, rready;             // Read side
	int          fails, num_checks;                            // Tallies
	logic [31:0] rnd = 32'h4f;                                 // Random state

	scb_top i_scb_top (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);
	scb_exec_model i_scb_exec_model (.aclk, .awaddr, .awprot, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);

	// 100 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	function automatic logic [31:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
		check_word({30'h0, got}, {30'h0, exp});
	endtask
	task automatic hang();
		fails++;
		$display("MISMATCH t=%0t bus wait ran out", $time);
		tally_and_finish();
	endtask
	task automatic bw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		bit ok;
		i_scb_exec_model.wr(a, d, r, ok);
		if (!ok)
			hang();
		check_resp(r, er);
	endtask
	task automatic br(input logic [5:0] a, output logic [31:0] d);
		logic [1:0] r;
		bit ok;
		i_scb_exec_model.rd(a, d, r, ok);
		if (!ok)
			hang();
		check_resp(r, `SCB_RESP_OKAY);
	endtask
	// Reference verdict straight from the flag tests; bit0 zero, 1 sign, 2 ovf, 3 parity
	function automatic int taken_of(input int op, input int f);
		int z = f & 1, s = (f >> 1) & 1, o = (f >> 2) & 1, p = (f >> 3) & 1;
		case (op)
			8'h7f: return !z && s == o;
			8'h71: return !o;
			8'h7b: return !p;
			8'h79: return !s;
			8'h75: return !z;
			8'h70: return o;
			8'h7a: return p;
			default: return 0;
		endcase
	endfunction
	// One branch: load, start, see it busy, wait for done, compare every result
	task automatic branch(input int op, input int dp, input int f, input int ip);
		int t, u, ext, nip;
		logic [31:0] d;
		t = taken_of(op, f);
		u = !(op inside {8'h70, 8'h71, 8'h75, 8'h79, 8'h7a, 8'h7b, 8'h7f});
		ext = dp >= 128 ? (16'hff00 | dp) : (16'h00ff & dp);
		nip = (ip + 2 + (t ? ext : 0)) % 65536;
		bw(`SCB_ADDR_INSN, 32'(dp * 256 + op), `SCB_RESP_OKAY);
		bw(`SCB_ADDR_FLAGS, 32'(f), `SCB_RESP_OKAY);
		bw(`SCB_ADDR_IP, 32'(ip), `SCB_RESP_OKAY);
		bw(`SCB_ADDR_CTRL, 32'h1, `SCB_RESP_OKAY);
		br(`SCB_ADDR_STATUS, d);
		check_word(d & 32'h1, 32'h1);
		for (int n = 0; n < 40 && d[1] !== 1'b1; n++)
			br(`SCB_ADDR_STATUS, d);
		// A branch that never finishes ends the run here
		if (d[1] !== 1'b1)
			hang();
		check_word(d, 32'({u[0], t[0], 2'b10}));
		br(`SCB_ADDR_NEXT_IP, d);
		check_word(d, 32'(nip));
		br(`SCB_ADDR_CYCLES, d);
		check_word(d, t ? 32'hd : 32'h4);
	endtask

	// Main sequence
	initial
	begin
		logic [31:0] d;
		int          ops[8];
		ops = '{8'h7f, 8'h71, 8'h7b, 8'h79, 8'h75, 8'h70, 8'h7a, 8'h74};
		fails = 0;
		num_checks = 0;
		aresetn = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values and readback with slow ready, then a refused address
		i_scb_exec_model.slow = 1;
		br(`SCB_ADDR_INSN, d);
		check_word(d, 32'h0);
		br(`SCB_ADDR_FLAGS, d);
		check_word(d, 32'h0);
		bw(`SCB_ADDR_IP, 32'h1234, `SCB_RESP_OKAY);
		br(`SCB_ADDR_IP, d);
		check_word(d, 32'h1234);
		bw(6'h1c, 32'h1, `SCB_RESP_SLVERR);
		i_scb_exec_model.slow = 0;
		// Seven handled opcodes plus unhandled 74 under every flag set; both sign edges and a wrapping pointer
		foreach (ops[i])
			for (int f = 0; f < 16; f++)
				branch(ops[i], f < 2 ? 128 - f : xs() & 255, f, f == 3 ? 65534 : xs() & 65535);
		tally_and_finish();
	end
endmodule // short_conditional_branch_unit_tb

bind scb_top scb_top_checker i_scb_top_checker (.aclk, .aresetn, .awaddr, .awvalid, .awready,
	.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
	.rvalid, .rready);
